// *** atimr_timer.sv ***
// Module: 16-bit interval timer/counter with APB registers and interrupt
// Function
// RULE1: one 16-bit counter, internal or external clock
// RULE2: four modes: internal, gated, sync external, async
// RULE3: enable bit 15 starts and stops counting
// RULE4: idle-stop bit 13 halts timer during idle
// RULE5: guard bit 12 ignores count writes while pending
// RULE6: guard clear allows back-to-back count writes
// RULE7: pending bit 11 shows unfinished async write
// RULE8: pending bit reads zero in synchronous mode
// RULE9: gate bit 7 active only on internal clock
// RULE10: prescale bits 5-4 select 1, 8, 64, 256
// RULE11: sync bit 2 matters only on external clock
// RULE12: source bit 1 picks pin or internal clock
// RULE13: unimplemented control bits always read zero
// RULE14: timer can keep running in sleep and idle
// RULE15: async mode runs from slow secondary oscillator
// RULE16: clear, set, invert aliases for control bits
// RULE17: tick increments; period match wraps, flags, triggers
// RULE18: reset clears all control bits to zero
`timescale 1ns/1ps
`default_nettype none
module atimr_timer (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Pins and power state
   input  wire logic        ext_timer_clock_pin,
   input  wire logic        idle_mode,
   input  wire logic        sleep_mode,
   // Event outputs
   output logic             adc_trigger,
   output logic             irq
);
   // =========================================================
   // Register state
   logic [31:0] con;        // Writable control bits only
   logic [15:0] count;      // Timer value
   logic [15:0] period;     // Wrap value
   logic [15:0] staged;     // Count value waiting for the pin clock
   logic        pending;    // Async count write not yet applied
   logic [1:0]  status;     // Sticky events
   logic [1:0]  mask;       // Event enables
   logic [31:0] rdata_q;    // Read data held for the access phase
   logic        err_q;      // Unmapped address seen in setup

   // =========================================================
   // Pin synchroniser; stage one feeds only stage two
   logic pin_s1;            // First stage
   logic pin_s2;            // Second stage
   logic pin_s3;            // Edge history
   logic pin_rise;          // Rising edge of the pin
   logic pin_fall;          // Falling edge of the pin

   // Sample the external pin through two flops; a third keeps edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         pin_s3 <= 1'b0;
      end else begin
         pin_s1 <= ext_timer_clock_pin;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   assign pin_rise = pin_s2 & ~pin_s3;
   assign pin_fall = ~pin_s2 & pin_s3;

   // =========================================================
   // Control field decode
   logic en;                // Counting enabled
   logic idle_stop;         // Halt while idle
   logic guard;             // Block count writes while pending
   logic gate_en;           // Gated accumulation requested
   logic ext_sync;          // Pin clock synchronised
   logic ext_src;           // Pin clock selected
   logic async_mode;        // Pin clock, unsynchronised
   logic gated;             // Gating in effect
   logic run;               // Counter may advance this cycle
   logic raw_tick;          // Pulse before the prescaler

   assign en         = con[atimr_pkg::BIT_ENABLE];
   assign idle_stop  = con[atimr_pkg::BIT_IDLE];
   assign guard      = con[atimr_pkg::BIT_GUARD];
   assign gate_en    = con[atimr_pkg::BIT_GATE];
   assign ext_sync   = con[atimr_pkg::BIT_SYNC];
   assign ext_src    = con[atimr_pkg::BIT_CSRC];                // RULE12
   assign async_mode = ext_src & ~ext_sync;                     // RULE11
   assign gated      = gate_en & ~ext_src;                      // RULE9
   // Idle halts only with idle-stop; in sleep the bus clock is
   // notionally gone, so only the pin-clocked async mode survives
   assign run = en                                              // RULE3
              & ~(idle_mode & idle_stop)                        // RULE4
              & ~(sleep_mode & ~async_mode);                    // RULE14
   // Internal clock counts every cycle, or while the gate pin is high;
   // either external mode counts pin rising edges
   assign raw_tick = ext_src ? pin_rise                         // RULE2
                   : (gated ? pin_s2 : 1'b1);                   // RULE2

   // =========================================================
   // Prescaler
   atimr_pre_if pre_link ();
   logic tick;              // Divided count pulse

   assign pre_link.tick_in = raw_tick & run;
   assign pre_link.clear   = ~en;
   assign pre_link.sel     = con[atimr_pkg::BIT_PS_HI:atimr_pkg::BIT_PS_LO];
   assign tick             = pre_link.tick_out;

   atimr_prescaler u_pre (
      .pclk    (pclk),
      .presetn (presetn),
      .pre     (pre_link.pre)
   );

   // =========================================================
   // APB decode
   logic setup_ph;          // Setup cycle
   logic wr_acc;            // Write taking effect now
   logic hit_con;           // Control word
   logic hit_alias;         // Any control alias
   logic hit_count;         // Count value
   logic hit_period;        // Wrap value
   logic hit_status;        // Sticky events
   logic hit_mask;          // Event mask
   logic hit_any;           // Mapped address
   logic wr_count;          // Count write accepted
   logic [3:0] alias_op;    // Control write operation

   assign setup_ph   = psel & ~penable;
   assign wr_acc     = psel & penable & pwrite;
   assign hit_con    = (paddr == atimr_pkg::OFF_CON);
   assign hit_alias  = (paddr == atimr_pkg::OFF_CON_CLR)
                     | (paddr == atimr_pkg::OFF_CON_SET)
                     | (paddr == atimr_pkg::OFF_CON_INV);
   assign hit_count  = (paddr == atimr_pkg::OFF_COUNT);
   assign hit_period = (paddr == atimr_pkg::OFF_PERIOD);
   assign hit_status = (paddr == atimr_pkg::OFF_STATUS);
   assign hit_mask   = (paddr == atimr_pkg::OFF_MASK);
   assign hit_any    = hit_con | hit_alias | hit_count | hit_period
                     | hit_status | hit_mask;
   // A guarded count write during a pending one is silently dropped
   assign wr_count   = wr_acc & hit_count & ~(guard & pending);  // RULE5

   assign alias_op = (paddr == atimr_pkg::OFF_CON_CLR) ? atimr_pkg::ALIAS_CLR
                   : (paddr == atimr_pkg::OFF_CON_SET) ? atimr_pkg::ALIAS_SET
                   : (paddr == atimr_pkg::OFF_CON_INV) ? atimr_pkg::ALIAS_INV
                   : atimr_pkg::ALIAS_WR;

   // Apply a plain, clear, set or invert write to the control word
   function automatic logic [31:0] apply_alias(input logic [3:0]  op,
                                               input logic [31:0] old,
                                               input logic [31:0] wd);
      logic [31:0] r;
      r = wd;
      if (op == atimr_pkg::ALIAS_CLR) begin
         r = old & ~wd;
      end else if (op == atimr_pkg::ALIAS_SET) begin
         r = old | wd;
      end else if (op == atimr_pkg::ALIAS_INV) begin
         r = old ^ wd;
      end
      return r & atimr_pkg::CON_WR_MASK;                         // RULE13
   endfunction

   // =========================================================
   // Read view
   logic        pend_rd;    // Pending bit as software sees it
   logic [31:0] con_rd;     // Control word readback
   logic [31:0] rd_mux;     // Selected read value

   assign pend_rd = pending & async_mode;                        // RULE8
   assign con_rd  = (con & atimr_pkg::CON_WR_MASK)               // RULE13
                  | ({31'h0, pend_rd} << atimr_pkg::BIT_PEND);   // RULE7
   assign rd_mux  = (hit_con | hit_alias) ? con_rd
                  : hit_count  ? {16'h0000, count}
                  : hit_period ? {16'h0000, period}
                  : hit_status ? {30'h0, status}
                  : hit_mask   ? {30'h0, mask}
                  : 32'h0000_0000;

   // Capture read data and error in setup; answer is always one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0000_0000;
         err_q   <= 1'b0;
      end else if (setup_ph) begin
         rdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
         err_q   <= ~hit_any;
      end
   end

   assign prdata  = rdata_q;
   assign pready  = psel & penable;
   assign pslverr = psel & penable & err_q;

   // =========================================================
   // Control and configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         con    <= atimr_pkg::CON_RESET;                         // RULE18
         period <= atimr_pkg::PERIOD_RESET;
         mask   <= atimr_pkg::EVT_RESET;
      end else if (wr_acc) begin
         if (hit_con | hit_alias) begin
            con <= apply_alias(alias_op, con, pwdata);           // RULE16
         end else if (hit_period) begin
            period <= pwdata[15:0];
         end else if (hit_mask) begin
            mask <= pwdata[1:0];
         end
      end
   end

   // =========================================================
   // Counter and async write staging
   logic wrap;              // Counter at its period on a tick
   logic async_done;        // Staged value lands on this pin edge

   assign wrap       = tick & (count == period);                 // RULE17
   // Async writes land on the next pin edge, as the slow clock would
   assign async_done = pending & pin_rise;                       // RULE15

   // Sync writes land at once; async ones wait for the pin clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count   <= atimr_pkg::COUNT_RESET;
         staged  <= atimr_pkg::COUNT_RESET;
         pending <= 1'b0;
      end else begin
         if (wr_count & async_mode) begin
            staged  <= pwdata[15:0];                             // RULE6
            pending <= 1'b1;                                     // RULE7
         end else if (async_done | ~async_mode) begin
            pending <= 1'b0;                                     // RULE7
         end
         if (wr_count & ~async_mode) begin
            count <= pwdata[15:0];
         end else if (async_done) begin
            count <= staged;
         end else if (wrap) begin
            count <= 16'h0000;                                   // RULE17
         end else if (tick) begin
            count <= count + 16'h0001;                           // RULE1
         end
      end
   end

   // =========================================================
   // Events, trigger and interrupt
   logic [1:0] evt;         // Events raised this cycle
   logic [1:0] w1c;         // Bits software clears now

   assign evt = {gated & en & pin_fall, wrap & ~async_done};     // RULE9
   assign w1c = (wr_acc & hit_status) ? pwdata[1:0] : 2'b00;

   // Sticky flags; a new event outweighs a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status      <= atimr_pkg::EVT_RESET;
         adc_trigger <= 1'b0;
      end else begin
         status      <= (status & ~w1c) | evt;                   // RULE17
         adc_trigger <= evt[atimr_pkg::EVT_WRAP];                // RULE17
      end
   end

   assign irq = |(status & mask);

   // =========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_async_wr;
      wr_count & async_mode & ~pending;
   endsequence
   sequence s_blocked_wr;
      wr_acc & hit_count & guard & pending & ~async_done;
   endsequence

   a_pend_sync_zero: assert property (                           // RULE8
      !async_mode |-> !con_rd[atimr_pkg::BIT_PEND])
      else $error("pending bit visible in synchronous mode");
   a_async_write_pend: assert property (                         // RULE7
      s_async_wr ##1 async_mode |-> con_rd[atimr_pkg::BIT_PEND])
      else $error("async count write did not raise pending");
   a_pend_clears: assert property (                              // RULE7
      async_done & ~wr_count |=> !pending && count == $past(staged))
      else $error("pending write did not land on pin edge");
   a_guard_blocks: assert property (                             // RULE5
      s_blocked_wr |=> $stable(staged))
      else $error("guarded count write was not ignored");
   a_no_guard_takes: assert property (                           // RULE6
      wr_acc & hit_count & ~guard & async_mode
      |=> staged == $past(pwdata[15:0]))
      else $error("back-to-back count write lost");
   a_period_wrap: assert property (                              // RULE17
      wrap & ~wr_count & ~async_done |=> count == 16'h0000 ##0 adc_trigger)
      else $error("period match did not wrap and trigger");
   a_stop_holds: assert property (                               // RULE3
      !en & !wr_count & !async_done |=> $stable(count))
      else $error("disabled timer advanced");
   a_idle_halt: assert property (                                // RULE4
      idle_mode & idle_stop & !wr_count & !async_done |=> $stable(count))
      else $error("timer ran in idle with idle-stop set");
   a_reserved_zero: assert property (                            // RULE13
      (con_rd & ~(atimr_pkg::CON_WR_MASK
         | (32'h1 << atimr_pkg::BIT_PEND))) == 32'h0)
      else $error("unimplemented control bit reads one");
   a_set_alias: assert property (                                // RULE16
      wr_acc & (paddr == atimr_pkg::OFF_CON_SET)
      |=> (con & ($past(pwdata) & atimr_pkg::CON_WR_MASK))
          == ($past(pwdata) & atimr_pkg::CON_WR_MASK))
      else $error("set alias did not set control bits");
   a_irq_level: assert property (
      $rose(status[atimr_pkg::EVT_WRAP]) & mask[atimr_pkg::EVT_WRAP]
      |-> irq)
      else $error("unmasked event did not raise interrupt");
   a_pend_leave: assert property (                               // RULE8
      !async_mode |=> !pending)
      else $error("pending write survived leaving async mode");
   a_sleep_halt: assert property (                               // RULE14
      sleep_mode & ~async_mode & !wr_count & !async_done
      |=> $stable(count))
      else $error("synchronous timer ran in sleep");
   a_slverr_map: assert property (
      setup_ph & ~hit_any |=> pslverr == (psel & penable))
      else $error("unmapped access did not flag an error");
endmodule
`default_nettype wire

// *** atimr_pkg.sv ***
// Package: register map, field positions and constants of the interval timer
package atimr_pkg;
   // =========================================================
   // Register byte offsets
   localparam logic [7:0]  OFF_CON      = 8'h00; // Control word
   localparam logic [7:0]  OFF_CON_CLR  = 8'h04; // Clear alias
   localparam logic [7:0]  OFF_CON_SET  = 8'h08; // Set alias
   localparam logic [7:0]  OFF_CON_INV  = 8'h0C; // Invert alias
   localparam logic [7:0]  OFF_COUNT    = 8'h10; // Count value
   localparam logic [7:0]  OFF_PERIOD   = 8'h20; // Wrap value
   localparam logic [7:0]  OFF_STATUS   = 8'h30; // Sticky events
   localparam logic [7:0]  OFF_MASK     = 8'h34; // Event mask
   // =========================================================
   // Control field positions
   localparam int BIT_ENABLE = 15;
   localparam int BIT_IDLE   = 13;
   localparam int BIT_GUARD  = 12;
   localparam int BIT_PEND   = 11;
   localparam int BIT_GATE   = 7;
   localparam int BIT_PS_HI  = 5;
   localparam int BIT_PS_LO  = 4;
   localparam int BIT_SYNC   = 2;
   localparam int BIT_CSRC   = 1;
   // Writable control bits; all others except pending bit 11 read as zero
   localparam logic [31:0] CON_WR_MASK  = 32'h0000_B0B6;
   // =========================================================
   // Reset values
   localparam logic [31:0] CON_RESET    = 32'h0000_0000;
   localparam logic [15:0] COUNT_RESET  = 16'h0000;
   localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
   localparam logic [1:0]  EVT_RESET    = 2'h0;
   // =========================================================
   // Event bits in status and mask
   localparam int EVT_WRAP = 0;
   localparam int EVT_GATE = 1;
   // =========================================================
   // Prescale codes and divide ratios
   localparam logic [1:0]  PS_1   = 2'h0;
   localparam logic [1:0]  PS_8   = 2'h1;
   localparam logic [1:0]  PS_64  = 2'h2;
   localparam logic [1:0]  PS_256 = 2'h3;
   localparam logic [7:0]  LIM_1   = 8'h00; // Divide ratio minus one
   localparam logic [7:0]  LIM_8   = 8'h07;
   localparam logic [7:0]  LIM_64  = 8'h3F;
   localparam logic [7:0]  LIM_256 = 8'hFF;
   // Alias operations applied to the control word
   typedef enum logic [3:0] {
      ALIAS_WR  = 4'b0001,
      ALIAS_CLR = 4'b0010,
      ALIAS_SET = 4'b0100,
      ALIAS_INV = 4'b1000
   } atimr_alias_t;
endpackage

// *** atimr_pre_if.sv ***
// Interface: tick path between the timer core and its prescaler
`timescale 1ns/1ps
`default_nettype none
interface atimr_pre_if;
   logic       tick_in;  // Raw count pulses
   logic       clear;    // Restart the divide chain
   logic [1:0] sel;      // Divide ratio code
   logic       tick_out; // Divided pulses
   modport core (output tick_in, output clear, output sel, input tick_out);
   modport pre  (input tick_in, input clear, input sel, output tick_out);
endinterface
`default_nettype wire

// *** atimr_prescaler.sv ***
// Module: divide-by-1/8/64/256 prescaler for the timer's count pulses
`timescale 1ns/1ps
`default_nettype none
module atimr_prescaler (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Tick path
   atimr_pre_if.pre  pre
);
   // =========================================================
   // Divide chain
   logic [7:0] cnt;   // Pulses seen since the last output tick
   logic [7:0] limit; // Ratio minus one for the chosen code
   logic       last;  // Chain at its final pulse

   // Ratio lookup, shared by decode and checks
   function automatic logic [7:0] ratio_limit(input logic [1:0] s);
      logic [7:0] r;
      r = atimr_pkg::LIM_1;
      if (s == atimr_pkg::PS_8) begin
         r = atimr_pkg::LIM_8;
      end else if (s == atimr_pkg::PS_64) begin
         r = atimr_pkg::LIM_64;
      end else if (s == atimr_pkg::PS_256) begin
         r = atimr_pkg::LIM_256;
      end
      return r;
   endfunction

   assign limit = ratio_limit(pre.sel);                      // RULE10
   assign last  = (cnt >= limit);
   // Output is a handshake pulse, so it stays combinational
   assign pre.tick_out = pre.tick_in & last & ~pre.clear;    // RULE10

   // Count input pulses; a ratio change mid-count ends early, never hangs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 8'h00;
      end else if (pre.clear) begin
         cnt <= 8'h00;
      end else if (pre.tick_in) begin
         cnt <= last ? 8'h00 : cnt + 8'h01;
      end
   end

   // =========================================================
   // Checks
   a_div_ratio: assert property (@(posedge pclk) disable iff (!presetn)
      pre.tick_out |-> cnt == ratio_limit(pre.sel))                 // RULE10
      else $error("prescaler ticked before its ratio was reached");
endmodule
`default_nettype wire

// *** atimr_pin_src.sv ***
// Partner model: clock or gate source on the timer's external pin
`timescale 1ns/1ps
`default_nettype none
module atimr_pin_src (
   // Pin to the timer
   output logic pin
);
   // =========================================
   // Pin driver
   // Rests low between bursts, like a stopped oscillator
   initial pin = 1'b0;
   // Burst of n rising edges; half sets fast or slow
   task automatic burst(input int n, input int half);
      for (int i = 0; i < n; i++) begin
         #(half) pin = 1'b1;
         #(half) pin = 1'b0;
      end
   endtask
   // Steady level, used as the gate
   task automatic hold(input logic lvl);
      pin = lvl;
   endtask
endmodule
`default_nettype wire

// *** test_async_capable_interval_timer.sv ***
// Testbench: self-checking run of the interval timer
`timescale 1ns/1ps
`default_nettype none
module test_async_capable_interval_timer;
   // =========================================
   // Signals
   localparam logic [7:0] CON = atimr_pkg::OFF_CON;   // Control word
   localparam logic [7:0] CNT = atimr_pkg::OFF_COUNT; // Count value
   logic        pclk = 1'b0;                       // Bus clock
   logic        presetn = 1'b0;                    // Reset, active low
   logic        psel = 1'b0, penable = 1'b0;       // APB phase
   logic        pwrite = 1'b0;                     // APB direction
   logic [7:0]  paddr = 8'h00;                     // APB address
   logic [31:0] pwdata = 32'h0;                    // APB write data
   logic [31:0] prdata;                            // APB read data
   logic        pready, pslverr, adc_trigger, irq; // Design outputs
   logic        idle_mode = 1'b0;                  // Power state
   logic        sleep_mode = 1'b0;                 // Power state
   wire         pin;                               // External pin
   int          errors = 0, compares = 0;          // Tallies
   logic [31:0] rd, rd0;                           // Last reads
   logic        err;                               // Last error flag
   // 250 MHz clock
   always #2 pclk = ~pclk;
   // =========================================
   // Design and partner
   atimr_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_timer_clock_pin(pin),
      .idle_mode(idle_mode), .sleep_mode(sleep_mode),
      .adc_trigger(adc_trigger), .irq(irq));
   atimr_pin_src src_u (.pin(pin));
   // =========================================
   // Shared tasks
   task automatic chk(input string w, input logic [31:0] s,
                      input logic [31:0] e);
      compares++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", w, e, s);
      end
   endtask
   // One APB transfer; waits for pready, no fixed latency assumed
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      chk("pready", 32'(pready), 32'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rc(input string w, input logic [7:0] a,
                     input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(w, rd, e);
   endtask
   // Two count reads whose captures lie k+3 edges apart
   task automatic span(input int k);
      apb(1'b0, CNT, 32'h0);
      rd0 = rd;
      repeat (k) @(posedge pclk);
      apb(1'b0, CNT, 32'h0);
   endtask
   task automatic final_report;
      if (errors == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // =========================================
   // Scenarios
   task automatic t_reset;
      rc("con", CON, 32'h0);
      rc("count", CNT, 32'h0);
      rc("period", atimr_pkg::OFF_PERIOD, 32'h0000_FFFF);
      apb(1'b0, 8'h40, 32'h0);
      chk("slverr", 32'(err), 32'h1);
      chk("unmapped", rd, 32'h0);
   endtask
   task automatic t_bits;
      wr(CON, 32'hFFFF_FFFF);
      rc("con_bits", CON, 32'h0000_B0B6);
      wr(atimr_pkg::OFF_CON_CLR, 32'hFFFF_FFFF);
      rc("con_clr", CON, 32'h0);
      wr(atimr_pkg::OFF_CON_SET, 32'h0000_8000);
      rc("con_set", CON, 32'h0000_8000);
      wr(atimr_pkg::OFF_CON_INV, 32'h0000_8002);
      rc("con_inv", CON, 32'h0000_0002);
   endtask
   task automatic t_wrap;
      int n;
      n = 0;
      wr(CON, 32'h0);
      wr(atimr_pkg::OFF_PERIOD, 32'h4);
      wr(CNT, 32'h0);
      wr(atimr_pkg::OFF_MASK, 32'h1);
      wr(CON, 32'h0000_8000);
      // Bounded wait for the trigger pulse
      while (adc_trigger !== 1'b1 && n < 20) begin
         @(negedge pclk);
         n++;
      end
      chk("adc_trigger", 32'(adc_trigger), 32'h1);
      wr(CON, 32'h0);
      @(negedge pclk);
      chk("irq_set", 32'(irq), 32'h1);
      apb(1'b0, CNT, 32'h0);
      chk("wrap_max", 32'(rd <= 32'h4), 32'h1);
      rc("stopped", CNT, rd);
      rc("status", atimr_pkg::OFF_STATUS, 32'h1);
      wr(atimr_pkg::OFF_MASK, 32'h0);
      @(negedge pclk);
      chk("irq_mask", 32'(irq), 32'h0);
      wr(atimr_pkg::OFF_MASK, 32'h1);
      wr(atimr_pkg::OFF_STATUS, 32'h1);
      @(negedge pclk);
      chk("irq_clr", 32'(irq), 32'h0);
   endtask
   task automatic t_ps;
      int sh[4] = '{0, 3, 6, 8};
      for (int c = 0; c < 4; c++) begin
         wr(CON, 32'h0);
         wr(atimr_pkg::OFF_PERIOD, 32'h0000_FFFF);
         wr(CNT, 32'h0);
         wr(CON, 32'h0000_8000 | (32'(c) << 4));
         span(509);
         chk("prescale", rd - rd0, 32'h200 >> sh[c]);
      end
   endtask
   task automatic t_idle;
      // Stop first so the old ratio's partial count is dropped
      wr(CON, 32'h0);
      wr(CON, 32'h0000_A000);
      @(posedge pclk);
      idle_mode <= 1'b1;
      span(20);
      chk("idle_stop", rd - rd0, 32'h0);
      wr(CON, 32'h0000_8000);
      span(20);
      chk("idle_run", rd - rd0, 32'h17);
      @(posedge pclk);
      idle_mode <= 1'b0;
   endtask
   task automatic t_pin;
      wr(CON, 32'h0);
      wr(CNT, 32'h0);
      wr(CON, 32'h0000_8086);
      src_u.burst(5, 40);
      repeat (10) @(posedge pclk);
      rc("ext_count", CNT, 32'h5);
      wr(CON, 32'h0);
      wr(CNT, 32'h0);
      wr(CON, 32'h0000_8080);
      span(20);
      chk("gate_low", rd - rd0, 32'h0);
      src_u.hold(1'b1);
      repeat (5) @(posedge pclk);
      span(17);
      chk("gate_high", rd - rd0, 32'h14);
      src_u.hold(1'b0);
      repeat (5) @(posedge pclk);
      rc("gate_evt", atimr_pkg::OFF_STATUS, 32'h2);
   endtask
   task automatic t_async;
      wr(CON, 32'h0);
      wr(CON, 32'h0000_8002);
      wr(CNT, 32'h1234);
      rc("pending", CON, 32'h0000_8802);
      wr(CNT, 32'h2222);
      @(posedge pclk);
      sleep_mode <= 1'b1;
      src_u.burst(1, 200);
      repeat (10) @(posedge pclk);
      rc("landed", CON, 32'h0000_8002);
      rc("second", CNT, 32'h2222);
      src_u.burst(3, 40);
      repeat (10) @(posedge pclk);
      rc("sleep_run", CNT, 32'h2225);
      @(posedge pclk);
      sleep_mode <= 1'b0;
      wr(CON, 32'h0000_9002);
      wr(CNT, 32'h1111);
      wr(CNT, 32'h3333);
      src_u.burst(1, 40);
      repeat (10) @(posedge pclk);
      rc("guarded", CNT, 32'h1111);
   endtask
   // =========================================
   // Main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_bits();
      t_wrap();
      t_ps();
      t_idle();
      t_pin();
      t_async();
      final_report();
   end
   // Watchdog: the run needs well under a fifth of this
   initial begin
      #200000;
      errors++;
      final_report();
   end
endmodule
`default_nettype wire
